// ===== design/bcs_pkg.sv
// Shared constants, types and register map of the buck control sequencer
package bcs_pkg;

	// Clock rate
	localparam int CLK_MHZ = 250;
	localparam int CLK_KHZ = 250000;

	// Printed times in their own units
	localparam real T_INIT_MAX_MS = 2.6;
	localparam real T_SOFT_START_MS = 1.0;
	localparam real T_SHORT_MS = 3.0;
	localparam real T_RESTART_S = 1.0;
	localparam int T_TON_MIN_HF_NS = 78;
	localparam int T_TON_MIN_LF_NS = 308;

	// Derived cycle counts (longest rounds down, least rounds up)
	localparam int INIT_CYC = int'($floor(T_INIT_MAX_MS * CLK_KHZ));
	localparam int SOFT_START_CYC = int'($floor(T_SOFT_START_MS * CLK_KHZ));
	localparam int SHORT_CYC = int'($floor(T_SHORT_MS * CLK_KHZ));
	localparam int RESTART_CYC = int'($floor(T_RESTART_S * CLK_KHZ * 1000.0));
	localparam int TON_HF_CYC = (T_TON_MIN_HF_NS * CLK_MHZ + 999) / 1000;
	localparam int TON_LF_CYC = (T_TON_MIN_LF_NS * CLK_MHZ + 999) / 1000;

	// Field widths
	localparam int TIMER_W = 28;
	localparam int SHORT_W = 20;
	localparam int PER_W = 12;
	localparam int BLANK_W = 7;
	localparam int REF_W = 8;
	localparam logic [REF_W-1:0] REF_FULL = 8'hFF;

	// Register byte offsets
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_PERIOD = 12'h004;
	localparam logic [11:0] OFF_STATUS = 12'h008;
	localparam logic [11:0] OFF_MASK = 12'h00C;
	localparam logic [11:0] OFF_STATE = 12'h010;

	// Reset values
	localparam logic CTRL_HF_RST = 1'b1;
	localparam logic [PER_W-1:0] PERIOD_RST = 12'h072;
	localparam logic [7:0] MASK_RST = 8'h00;

	// Status and mask bit positions
	localparam int EV_STARTED = 0;
	localparam int EV_OVERCUR = 1;
	localparam int EV_OVERLOAD = 2;
	localparam int EV_SHORT = 3;
	localparam int EV_INPUT_UV = 4;
	localparam int EV_THERMAL = 5;
	localparam int EV_FULL_DUTY = 6;
	localparam int EV_SKIP = 7;

	// Sequencer states
	typedef enum logic [6:0] {
		BCS_OFF        = 7'h01,
		BCS_INIT       = 7'h02,
		BCS_SOFT_START = 7'h04,
		BCS_RUN        = 7'h08,
		BCS_SHORT_WAIT = 7'h10,
		BCS_THERM_COOL = 7'h20,
		BCS_THERM_WAIT = 7'h40
	} bcs_state_t;

	// Analog comparator inputs
	typedef struct packed {
		logic input_startup_threshold;
		logic input_shutdown_threshold;
		logic peak_overcurrent_limit;
		logic overload_current_limit;
		logic output_undervoltage;
		logic temp_shutdown;
		logic temp_cooled;
		logic pwm_trip;
		logic input_near_output;
	} bcs_sense_t;

	// Whole module state
	typedef struct packed {
		bcs_state_t         st;
		logic [TIMER_W-1:0] timer;
		logic [SHORT_W-1:0] short_cnt;
		logic [PER_W-1:0]   cyc_cnt;
		logic [BLANK_W-1:0] blank;
		logic               hs_on;
		logic               ls_on;
		logic               discharge;
		logic               supervise_en;
		logic               ol_block;
		logic               full_duty;
		logic [REF_W-1:0]   ref_level;
		logic               cfg_hf;
		logic [PER_W-1:0]   cfg_period;
		logic               act_hf;
		logic [PER_W-1:0]   act_period;
		logic [7:0]         status;
		logic [7:0]         mask;
		logic               irq;
		logic               pready;
		logic               pslverr;
		logic [31:0]        prdata;
	} bcs_regs_t;

endpackage

// ===== design/bcs_sequencer.sv
// Control sequencer of the step-down regulator with APB registers
`timescale 1ns/100ps

// Contract
// R1: Enable high above startup threshold starts up
// R2: Init latches frequency, supervision, then ramps reference
// R3: Initialization lasts at most 2.6 ms
// R4: Soft-start ramp takes about 1 ms
// R5: Enable low turns on switch node discharge
// R6: Peak overcurrent after blanking ends high side pulse
// R7: Low side overload blocks next high side pulses
// R8: Overload with undervoltage for 3 ms shuts down
// R9: Short-circuit shutdown restarts after 1 s
// R10: Input undervoltage shuts the regulator down
// R11: Thermal shutdown turns the device off
// R12: Cooled plus 1 s wait restarts with soft-start
// R13: Input near output holds high side on
// R14: Too short off-times skip switching cycles
// R15: Minimum on-time 78 ns high, 308 ns low range
// R16: Blanking sets minimum on-time and marks PFM; no PFM mark is kept
// R17: Every shutdown forces both switches off first
// R18: Every restart passes init and soft-start again
module bcs_sequencer
	import bcs_pkg::*;
#(
	parameter int ADDR_W         = 12,
	parameter int INIT_CYCLES    = INIT_CYC,
	parameter int SS_CYCLES      = SOFT_START_CYC,
	parameter int SHORT_CYCLES   = SHORT_CYC,
	parameter int RESTART_CYCLES = RESTART_CYC
) (
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              enable,
	input  wire bcs_sense_t        sense,
	output logic                   hs_switch_on,
	output logic                   ls_switch_on,
	output logic                   switch_node_discharge,
	output logic                   supervise_en,
	output logic                   freq_high_range,
	output logic [PER_W-1:0]       switch_period,
	output logic [REF_W-1:0]       ref_level,
	output logic                   irq,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr
);

	// Soft-start step length per reference code
	localparam int SS_STEP = (SS_CYCLES / 255 > 0) ? SS_CYCLES / 255 : 1;

	bcs_regs_t r;
	bcs_regs_t n;
	logic      cyc_pulse;
	logic      regulating;
	logic      trip;
	logic      rd_status_fire;
	logic [7:0] ev;
	logic [BLANK_W-1:0] ton_min;
	logic [11:0] addr;

	// Switching cycle start pulse and per-range on-time
	assign cyc_pulse = (r.cyc_cnt == '0);
	assign regulating = (r.st == BCS_SOFT_START) || (r.st == BCS_RUN);
	assign ton_min = r.act_hf ? BLANK_W'(TON_HF_CYC) : BLANK_W'(TON_LF_CYC); // [R15]
	assign trip = sense.peak_overcurrent_limit || (sense.pwm_trip && !sense.input_near_output);
	assign addr = 12'(paddr);
	assign rd_status_fire = psel && penable && r.pready && !pwrite && (addr == OFF_STATUS);

	// Next state of everything
	always_comb begin
		n = r;
		ev = 8'h00;
		n.pready = 1'b0;
		n.pslverr = 1'b0;

		// APB: answer one cycle into the access phase
		if (psel && penable && !r.pready) begin
			n.pready = 1'b1;
			n.prdata = 32'h0000_0000;
			unique case (addr)
				OFF_CTRL:   n.prdata = {31'h0, r.cfg_hf};
				OFF_PERIOD: n.prdata = {20'h0_0000, r.cfg_period};
				OFF_STATUS: n.prdata = {24'h00_0000, r.status};
				OFF_MASK:   n.prdata = {24'h00_0000, r.mask};
				OFF_STATE:  n.prdata = {13'h0000, r.ls_on, r.hs_on, r.discharge,
					r.ref_level, 1'b0, r.st};
				default:    n.pslverr = 1'b1;
			endcase
		end
		if (psel && penable && r.pready && pwrite) begin
			unique case (addr)
				OFF_CTRL:   n.cfg_hf = pwdata[0];
				OFF_PERIOD: n.cfg_period = pwdata[PER_W-1:0];
				OFF_MASK:   n.mask = pwdata[7:0];
				default:    n.mask = r.mask;
			endcase
		end

		// Switching clock divider
		if (r.cyc_cnt >= r.act_period - 12'h001) begin
			n.cyc_cnt = '0;
		end else begin
			n.cyc_cnt = r.cyc_cnt + 12'h001;
		end

		// Discharge is the inverted enable pin, registered one cycle later
		n.discharge = !enable; // [R5]

		// Sequencer, shutdown causes first
		if (sense.input_shutdown_threshold) begin
			if (r.st != BCS_OFF) begin
				ev[EV_INPUT_UV] = 1'b1;
			end
			n.st = BCS_OFF; // [R10] [R17]
		end else if (sense.temp_shutdown && (r.st != BCS_THERM_COOL)) begin
			if (r.st != BCS_THERM_WAIT) begin
				ev[EV_THERMAL] = 1'b1;
			end
			n.st = BCS_THERM_COOL; // [R11] [R17]
		end else if (!enable && (regulating || (r.st == BCS_INIT))) begin
			n.st = BCS_OFF; // [R17]
		end else begin
			unique case (r.st)
				BCS_OFF: begin
					if (enable && sense.input_startup_threshold) begin
						n.st = BCS_INIT; // [R1] [R18]
						n.timer = '0;
					end
				end
				BCS_INIT: begin
					// Take configuration on the first init cycle
					if (r.timer == '0) begin
						n.act_hf = r.cfg_hf; // [R2]
						n.act_period = r.cfg_period;
						n.supervise_en = 1'b1;
					end
					n.timer = r.timer + 28'h000_0001;
					// Leave one cycle early: the step out of OFF counts toward the limit
					if (r.timer >= TIMER_W'(INIT_CYCLES - 2)) begin
						n.st = BCS_SOFT_START; // [R3]
						n.timer = '0;
						n.ref_level = '0;
					end
				end
				BCS_SOFT_START, BCS_RUN: begin
					// Reference ramp, one code per step
					if (r.st == BCS_SOFT_START) begin
						n.timer = r.timer + 28'h000_0001;
						if (r.timer >= TIMER_W'(SS_STEP - 1)) begin
							n.timer = '0;
							n.ref_level = r.ref_level + 8'h01; // [R4] [R2]
							if (r.ref_level == REF_FULL - 8'h01) begin
								n.st = BCS_RUN;
								ev[EV_STARTED] = 1'b1;
							end
						end
					end
					// Short circuit: overload and undervoltage together
					if (r.ol_block && sense.output_undervoltage) begin
						n.short_cnt = r.short_cnt + 20'h0_0001;
						if (r.short_cnt >= SHORT_W'(SHORT_CYCLES - 1)) begin
							n.st = BCS_SHORT_WAIT; // [R8] [R17]
							n.timer = '0;
							ev[EV_SHORT] = 1'b1;
						end
					end else begin
						n.short_cnt = '0;
					end
				end
				BCS_SHORT_WAIT: begin
					n.timer = r.timer + 28'h000_0001;
					if (r.timer >= TIMER_W'(RESTART_CYCLES - 1)) begin
						n.st = BCS_INIT; // [R9] [R18]
						n.timer = '0;
					end
				end
				BCS_THERM_COOL: begin
					if (sense.temp_cooled && !sense.temp_shutdown) begin
						n.st = BCS_THERM_WAIT; // [R12]
						n.timer = '0;
					end
				end
				BCS_THERM_WAIT: begin
					n.timer = r.timer + 28'h000_0001;
					if (r.timer >= TIMER_W'(RESTART_CYCLES - 1)) begin
						n.st = BCS_INIT; // [R12] [R18]
						n.timer = '0;
					end
				end
			endcase
		end

		// Power stage drive
		if (regulating && ((n.st == BCS_SOFT_START) || (n.st == BCS_RUN))) begin
			if (cyc_pulse) begin
				if (r.ol_block) begin
					n.hs_on = 1'b0; // [R7]
					n.ls_on = 1'b1;
					n.ol_block = 1'b0;
				end else if (sense.input_near_output) begin
					n.hs_on = 1'b1; // [R13]
					n.ls_on = 1'b0;
					if (!r.full_duty) begin
						ev[EV_FULL_DUTY] = 1'b1;
					end
					n.full_duty = 1'b1;
				end else if (r.hs_on && r.blank == '0) begin
					// No off-time reached: skip this cycle's off phase
					ev[EV_SKIP] = 1'b1; // [R14]
					n.full_duty = 1'b0;
				end else begin
					n.hs_on = 1'b1;
					n.ls_on = 1'b0;
					// Load one less so the pulse lasts exactly the minimum
					n.blank = ton_min - 7'h01; // [R16]
					n.full_duty = 1'b0;
				end
			end else if (r.hs_on && r.blank != '0) begin
				n.blank = r.blank - 7'h01; // [R16]
			end else if (r.hs_on && trip) begin
				n.hs_on = 1'b0; // [R6]
				n.ls_on = 1'b1;
				if (sense.peak_overcurrent_limit) begin
					ev[EV_OVERCUR] = 1'b1;
				end
			end
			if (r.ls_on && sense.overload_current_limit) begin
				n.ol_block = 1'b1; // [R7]
				ev[EV_OVERLOAD] = 1'b1;
			end
		end else begin
			n.hs_on = 1'b0; // [R17]
			n.ls_on = 1'b0;
			n.ol_block = 1'b0;
			n.blank = '0;
			n.full_duty = 1'b0;
		end

		// Leaving regulation drops reference and supervision
		if ((n.st != BCS_SOFT_START) && (n.st != BCS_RUN) && (n.st != BCS_INIT)) begin
			n.ref_level = '0;
			n.supervise_en = 1'b0;
			n.short_cnt = '0;
		end

		// Sticky events, a new event wins over the read clear
		n.status = (r.status & ~(rd_status_fire ? r.prdata[7:0] : 8'h00)) | ev;
		n.irq = |(n.status & n.mask);
	end

	// State register
	always_ff @(posedge clk) begin
		if (reset) begin
			r <= '0;
			r.st <= BCS_OFF;
			r.cfg_hf <= CTRL_HF_RST;
			r.cfg_period <= PERIOD_RST;
			r.act_hf <= CTRL_HF_RST;
			r.act_period <= PERIOD_RST;
			r.mask <= MASK_RST;
		end else begin
			r <= n;
		end
	end

	// Outputs straight from the state register
	assign hs_switch_on = r.hs_on;
	assign ls_switch_on = r.ls_on;
	assign switch_node_discharge = r.discharge;
	assign supervise_en = r.supervise_en;
	assign freq_high_range = r.act_hf;
	assign switch_period = r.act_period;
	assign ref_level = r.ref_level;
	assign irq = r.irq;
	assign pready = r.pready;
	assign prdata = r.prdata;
	assign pslverr = r.pslverr;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_off_ready;
		(r.st == BCS_OFF) && enable && sense.input_startup_threshold
			&& !sense.input_shutdown_threshold && !sense.temp_shutdown;
	endsequence

	sequence s_short_full;
		regulating && r.ol_block && sense.output_undervoltage && !sense.input_shutdown_threshold
			&& !sense.temp_shutdown && enable && (r.short_cnt == SHORT_W'(SHORT_CYCLES - 1));
	endsequence

	a_startup_launch: assert property (s_off_ready |=> (r.st == BCS_INIT)) // [R1]
		else $error("startup not launched");
	a_init_bound: assert property ((r.st == BCS_INIT) |-> (r.timer < TIMER_W'(INIT_CYCLES))) // [R3]
		else $error("init phase too long");
	a_init_latch: assert property ($rose(r.st == BCS_SOFT_START) // [R2]
		|-> r.supervise_en && (r.ref_level == '0))
		else $error("ramp started without setup");
	a_restart_path: assert property ($rose(r.st == BCS_SOFT_START) |-> $past(r.st) == BCS_INIT) // [R18]
		else $error("soft start not entered from init");
	a_discharge_low: assert property (!enable |=> switch_node_discharge) // [R5]
		else $error("discharge off while enable low");
	a_oc_cutoff: assert property (regulating && r.hs_on && r.blank == '0 && !cyc_pulse // [R6]
		&& sense.peak_overcurrent_limit |=> !hs_switch_on)
		else $error("high side not cut by overcurrent");
	a_blank_hold: assert property (regulating && r.hs_on && r.blank != '0 && !cyc_pulse // [R16]
		&& enable && !sense.input_shutdown_threshold && !sense.temp_shutdown
		&& r.st == $past(r.st) && (r.short_cnt < SHORT_W'(SHORT_CYCLES - 1))
		|=> hs_switch_on)
		else $error("high side cut during blanking");
	a_ol_block: assert property (r.ol_block && cyc_pulse |=> !hs_switch_on) // [R7]
		else $error("high side on during overload");
	a_short_shut: assert property (s_short_full |=> (r.st == BCS_SHORT_WAIT) && !hs_switch_on) // [R8]
		else $error("short circuit not shut down");
	a_uv_off: assert property (sense.input_shutdown_threshold // [R10] [R17]
		|=> (r.st == BCS_OFF) && !hs_switch_on && !ls_switch_on)
		else $error("undervoltage did not shut down");
	a_thermal_off: assert property (sense.temp_shutdown // [R11]
		&& !sense.input_shutdown_threshold
		|=> (r.st == BCS_THERM_COOL) && !hs_switch_on && !ls_switch_on)
		else $error("thermal shutdown missed");
	a_therm_wait: assert property ((r.st == BCS_THERM_WAIT) && (r.st != $past(r.st)) // [R12]
		|-> $past(sense.temp_cooled) && !$past(sense.temp_shutdown))
		else $error("restart wait before cooling");
	a_full_duty: assert property (regulating && cyc_pulse && sense.input_near_output // [R13]
		&& !r.ol_block && enable && !sense.input_shutdown_threshold && !sense.temp_shutdown
		&& (r.short_cnt == '0) |=> hs_switch_on)
		else $error("full duty not held");
	a_ss_ramp: assert property ((r.st == BCS_SOFT_START) |-> (r.timer < TIMER_W'(SS_STEP))) // [R4]
		else $error("soft start step overrun");
	a_no_shoot: assert property (!(hs_switch_on && ls_switch_on)) // [R17]
		else $error("both switches on");

	// Startup: init ends on time and the ramp steps one code at a time
	sequence s_init_done;
		(r.st == BCS_INIT) && enable && !sense.input_shutdown_threshold && !sense.temp_shutdown
			&& (r.timer == TIMER_W'(INIT_CYCLES - 2));
	endsequence

	a_init_exit: assert property (s_init_done |=> (r.st == BCS_SOFT_START)) // [R3]
		else $error("init phase did not end");
	a_ss_step: assert property ((r.st == BCS_SOFT_START) // [R4]
		&& (r.timer == TIMER_W'(SS_STEP - 1)) && enable && !sense.input_shutdown_threshold
		&& !sense.temp_shutdown && (r.short_cnt < SHORT_W'(SHORT_CYCLES - 1))
		|=> (r.ref_level == $past(r.ref_level) + 8'h01))
		else $error("reference step missed");

	// Shutdown by enable, and the timed restarts after faults
	a_enable_off: assert property (!enable && (regulating || (r.st == BCS_INIT)) // [R17]
		&& !sense.input_shutdown_threshold && !sense.temp_shutdown
		|=> (r.st == BCS_OFF) && !hs_switch_on && !ls_switch_on)
		else $error("enable low did not stop the regulator");

	sequence s_wait_done;
		((r.st == BCS_SHORT_WAIT) || (r.st == BCS_THERM_WAIT)) && !sense.input_shutdown_threshold
			&& !sense.temp_shutdown && (r.timer == TIMER_W'(RESTART_CYCLES - 1));
	endsequence

	a_restart_due: assert property (s_wait_done // [R9] [R12]
		|=> (r.st == BCS_INIT) && (r.timer == '0))
		else $error("restart wait did not end");
	a_short_hold: assert property ((r.st == BCS_SHORT_WAIT) // [R9]
		&& !sense.input_shutdown_threshold && !sense.temp_shutdown
		&& (r.timer < TIMER_W'(RESTART_CYCLES - 1)) |=> (r.st == BCS_SHORT_WAIT))
		else $error("short restart came early");

	// Near full duty a pulse still running at the cycle start is kept on
	a_skip_hold: assert property (regulating && cyc_pulse && r.hs_on && (r.blank == '0) // [R14]
		&& !r.ol_block && !sense.input_near_output && enable
		&& !sense.input_shutdown_threshold && !sense.temp_shutdown
		|=> hs_switch_on && r.status[EV_SKIP])
		else $error("cycle not skipped");

endmodule

// ===== verification/bcs_partner.sv
// Behavioural model of the power stage current comparators and regulation loop
`timescale 1ns/100ps
module bcs_partner
	import bcs_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       hs_switch_on,
	input  wire logic       ls_switch_on,
	input  wire bcs_sense_t want,
	output bcs_sense_t      sense
);
	int on_cnt = 0;

	// Length of the present high side conduction phase
	always @(posedge clk) begin
		if (hs_switch_on === 1'b1)
			on_cnt <= on_cnt + 1;
		else
			on_cnt <= 0;
	end

	// Currents show only while their switch conducts
	// The bench's trip bit asks for an on-time longer than a period
	always_comb begin
		sense = want;
		sense.peak_overcurrent_limit = want.peak_overcurrent_limit & hs_switch_on;
		sense.overload_current_limit = want.overload_current_limit & ls_switch_on;
		sense.pwm_trip = hs_switch_on & (on_cnt >= (want.pwm_trip ? 200 : 30));
	end
endmodule

// ===== verification/bcs_sequencer_test.sv
// Self-checking bench of the buck control sequencer
`timescale 1ns/100ps
module bcs_sequencer_test
	import bcs_pkg::*;
;
	localparam int INIT_N = 40;
	localparam int SS_N   = 510;
	localparam int RST_N  = 50;

	logic             clk, reset, enable, psel, penable, pwrite;
	logic [11:0]      paddr;
	logic [31:0]      pwdata, prdata, rd;
	logic             hs, ls, dis, sup, fhr, irq, pready, pslverr, err_seen;
	logic [PER_W-1:0] per;
	logic [REF_W-1:0] ref_l;
	bcs_sense_t       sense, req;
	int               errors, n_compared, n;
	int               run = 0;
	int               last_on = 0;

	bcs_sequencer #(.INIT_CYCLES(INIT_N), .SS_CYCLES(SS_N), .SHORT_CYCLES(30),
		.RESTART_CYCLES(RST_N)) dut_u (
		.clk(clk), .reset(reset), .enable(enable), .sense(sense), .hs_switch_on(hs),
		.ls_switch_on(ls), .switch_node_discharge(dis), .supervise_en(sup),
		.freq_high_range(fhr), .switch_period(per), .ref_level(ref_l), .irq(irq),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr));
	bcs_partner pm_u (.clk(clk), .hs_switch_on(hs), .ls_switch_on(ls), .want(req),
		.sense(sense));

	// Clock source
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Length of the last finished high side pulse
	always @(posedge clk) begin
		if (hs === 1'b1)
			run <= run + 1;
		else begin
			if (run > 0)
				last_on <= run;
			run <= 0;
		end
	end

	task automatic ok(input string nm, input logic c);
		n_compared++;
		if (c !== 1'b1) begin
			errors++;
			$display("[ERR] %s expected 1 seen %b", nm, c);
		end
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic end_sim;
		if (errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// One APB transfer, released one edge after completion
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) begin
			errors++;
			end_sim();
		end
		@(posedge clk);
	endtask

	// Poll the state register, counting reads of four cycles each
	task automatic wait_state(input logic [6:0] s, output int cnt);
		cnt = 0;
		do begin
			apb(1'b0, OFF_STATE, 32'h0);
			cnt++;
		end while (rd[6:0] !== s && cnt < 400);
		if (cnt >= 400) begin
			errors++;
			end_sim();
		end
	endtask

	// Wait until the reference reaches a code, counting cycles
	task automatic wait_ref(input logic [7:0] lvl, output int cnt);
		cnt = 0;
		while (ref_l < lvl && cnt < 5000) begin
			@(posedge clk);
			cnt++;
		end
		if (cnt >= 5000) begin
			errors++;
			end_sim();
		end
	endtask

	task automatic status_bit(input string nm, input int b);
		apb(1'b0, OFF_STATUS, 32'h0);
		ok(nm, rd[b]);
	endtask

	// Main sequence
	initial begin
		errors = 0;
		n_compared = 0;
		reset = 1'b1;
		enable = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		req = '0;
		req.input_startup_threshold = 1'b1;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		// Reset values, unmapped place, discharge while disabled
		apb(1'b0, OFF_CTRL, 32'h0);
		chk("ctrl", 32'h1, rd);
		apb(1'b0, OFF_PERIOD, 32'h0);
		chk("period", 32'h72, rd);
		apb(1'b0, OFF_MASK, 32'h0);
		chk("mask", 32'h0, rd);
		apb(1'b0, OFF_STATE, 32'h0);
		chk("off state", 32'h10001, rd);
		apb(1'b1, 12'hFF0, 32'h0);
		ok("unmapped error", err_seen);
		// Startup: initialization then reference ramp
		enable <= 1'b1;
		wait_ref(8'h01, n);
		ok("init time", n <= INIT_N + SS_N / 255 + 1);
		ok("supervision", sup);
		chk("period latched", 32'h72, 32'(per));
		wait_ref(8'h0D, n);
		wait_ref(8'hF2, n);
		ok("ramp time", n >= SS_N * 8 / 10 && n <= SS_N * 12 / 10);
		wait_state(7'h08, n);
		// Masked event, then unmasked, then read clear
		ok("irq masked", irq === 1'b0);
		apb(1'b1, OFF_MASK, 32'hFF);
		repeat (2) @(posedge clk);
		ok("irq raised", irq);
		status_bit("started", EV_STARTED);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk("status cleared", 32'h0, rd);
		repeat (2) @(posedge clk);
		ok("irq cleared", irq === 1'b0);
		// Peak overcurrent cuts the pulse after blanking
		req.peak_overcurrent_limit <= 1'b1;
		repeat (400) @(posedge clk);
		ok("on time hf", last_on >= TON_HF_CYC && last_on <= TON_HF_CYC + 3);
		req.peak_overcurrent_limit <= 1'b0;
		status_bit("overcurrent", EV_OVERCUR);
		// Off-time too short skips cycles, dropout holds the high side
		req.pwm_trip <= 1'b1;
		repeat (400) @(posedge clk);
		status_bit("skip", EV_SKIP);
		req.pwm_trip <= 1'b0;
		req.input_near_output <= 1'b1;
		repeat (400) @(posedge clk);
		ok("full duty", run >= 250);
		status_bit("full duty", EV_FULL_DUTY);
		req.input_near_output <= 1'b0;
		// Overload with output undervoltage becomes a short
		req.overload_current_limit <= 1'b1;
		req.output_undervoltage <= 1'b1;
		wait_state(7'h10, n);
		ok("short off", hs === 1'b0 && ls === 1'b0);
		req.overload_current_limit <= 1'b0;
		req.output_undervoltage <= 1'b0;
		wait_state(7'h02, n);
		ok("short restart", n * 4 >= RST_N - 8 && n * 4 <= RST_N + 12);
		status_bit("overload", EV_OVERLOAD);
		wait_state(7'h04, n);
		wait_state(7'h08, n);
		// Input undervoltage
		req.input_shutdown_threshold <= 1'b1;
		apb(1'b0, OFF_STATE, 32'h0);
		chk("uv state", 32'h00001, rd & 32'h7FFFF);
		req.input_shutdown_threshold <= 1'b0;
		wait_state(7'h02, n);
		wait_state(7'h08, n);
		// Thermal shutdown, cool-down and wait
		req.temp_shutdown <= 1'b1;
		apb(1'b0, OFF_STATE, 32'h0);
		chk("thermal state", 32'h20, rd & 32'h6007F);
		req.temp_shutdown <= 1'b0;
		req.temp_cooled <= 1'b1;
		wait_state(7'h40, n);
		req.temp_cooled <= 1'b0;
		wait_state(7'h02, n);
		ok("thermal restart", n * 4 >= RST_N - 8 && n * 4 <= RST_N + 12);
		status_bit("thermal", EV_THERMAL);
		// Enable low, then restart in the low range
		enable <= 1'b0;
		repeat (3) @(posedge clk);
		ok("discharge", dis);
		apb(1'b1, OFF_CTRL, 32'h0);
		enable <= 1'b1;
		wait_state(7'h08, n);
		ok("low range", fhr === 1'b0);
		req.peak_overcurrent_limit <= 1'b1;
		repeat (400) @(posedge clk);
		ok("on time lf", last_on >= TON_LF_CYC && last_on <= TON_LF_CYC + 3);
		end_sim();
	end
endmodule
